// ==== include/gpw_defines.svh ====
`ifndef GPW_DEFINES_SVH
`define GPW_DEFINES_SVH

// Byte offsets inside one port slot
`define GPW_PORT_STRIDE 8'h10
`define GPW_OFS_DATA 4'h0
`define GPW_OFS_DIR 4'h4
`define GPW_OFS_PULL 4'h8
// Shared registers, slot 7
`define GPW_MISC_SLOT 3'h7
`define GPW_ADDR_WAKE 8'h70
`define GPW_ADDR_CTRL 8'h74
`define GPW_ADDR_STAT 8'h78
`define GPW_ADDR_MASK 8'h7c

// Control register fields
`define GPW_CTRL_HALT_BIT 0
`define GPW_CTRL_IDLE_BIT 1
// Status register fields
`define GPW_STAT_WAKE_BIT 0

// Reset values
`define GPW_RST_DATA 8'h00
`define GPW_RST_DIR 8'hff
`define GPW_RST_PULL 8'h00
`define GPW_RST_WAKE 8'h00
`define GPW_RST_STAT 8'h00
`define GPW_RST_MASK 8'h00

// Implemented pins per port
`define GPW_MASK_FULL 8'hff
`define GPW_MASK_B_SMALL 8'h3f
`define GPW_MASK_C_SMALL 8'h0f
`define GPW_MASK_F_MID 8'h03
`define GPW_MASK_G 8'h03
`define GPW_MASK_NONE 8'h00

// Bus responses
`define GPW_RESP_OKAY 2'h0
`define GPW_RESP_DECERR 2'h3

`endif

// ==== include/gpw_pkg.sv ====
package gpw_pkg;
  typedef enum logic [1:0] {
    GPW_RUN,
    GPW_SLEEP,
    GPW_IDLE
  } gpw_state_e;

  typedef logic [7:0] gpw_byte_t;
endpackage

// ==== src/gpw_ports.sv ====
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`include "gpw_defines.svh"
`default_nettype none

module gpw_ports
  import gpw_pkg::*;
#(
  parameter int CONFIG = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [55:0] pins_in,
  output logic [55:0] pins_out,
  output logic [55:0] pins_oe,
  output logic [55:0] pins_pullup,
  output logic core_halted,
  output logic core_idle,
  output logic wake,
  output logic irq
);

  // Pins implemented for a port in the chosen configuration
  function automatic gpw_byte_t impl_mask(input logic [2:0] p);
    gpw_byte_t m;
    m = `GPW_MASK_NONE;
    unique case (p)
      3'd0: m = `GPW_MASK_FULL;
      3'd1: m = (CONFIG < 2) ? `GPW_MASK_B_SMALL : `GPW_MASK_FULL;
      3'd2: m = (CONFIG == 0) ? `GPW_MASK_C_SMALL : `GPW_MASK_FULL;
      3'd3, 3'd4: m = (CONFIG >= 2) ? `GPW_MASK_FULL : `GPW_MASK_NONE;
      3'd5: begin
        m = `GPW_MASK_NONE;
        if (CONFIG == 2) m = `GPW_MASK_F_MID;
        if (CONFIG == 3) m = `GPW_MASK_FULL;
      end
      3'd6: m = (CONFIG == 3) ? `GPW_MASK_G : `GPW_MASK_NONE;
      default: m = `GPW_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic unmapped(input logic [7:0] a);
    return a[7] | ((a[6:4] != `GPW_MISC_SLOT) && (a[3:2] == 2'h3));
  endfunction

  gpw_byte_t data_q [7];
  gpw_byte_t dir_q [7];
  gpw_byte_t pull_q [7];
  gpw_byte_t wake_en;
  gpw_byte_t stat;
  gpw_byte_t mask;
  gpw_state_e state;

  logic [55:0] pin_meta;
  logic [55:0] pin_sync;
  gpw_byte_t pa_prev;

  logic aw_have;
  logic w_have;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic wr_fire;
  logic wr_ok;
  logic [2:0] wr_port;
  gpw_byte_t wr_val;
  gpw_byte_t next_rdata;
  gpw_byte_t fall;
  logic wake_hit;

  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;
  assign wr_ok = wr_fire & w_strb_q & ~unmapped(aw_addr_q);
  assign wr_port = aw_addr_q[6:4];
  assign wr_val = w_data_q & impl_mask(wr_port);

  // Two-flop synchroniser on every pad
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pa_prev <= '0;
    end else begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
      pa_prev <= pin_sync[7:0];
    end
  end

  // Falling edge on wake-enabled port A pins
  assign fall = wake_en & pa_prev & ~pin_sync[7:0];
  assign wake_hit = (state != GPW_RUN) && (fall != 8'h00);

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      aw_addr_q <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have <= 1'b1;
      w_data_q <= s_axi_wdata[7:0];
      w_strb_q <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPW_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= unmapped(aw_addr_q) ? `GPW_RESP_DECERR : `GPW_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Port registers; writes drop unimplemented bits, but reset loads dir with all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 7; p++) begin
        data_q[p] <= `GPW_RST_DATA;
        dir_q[p] <= `GPW_RST_DIR;
        pull_q[p] <= `GPW_RST_PULL;
      end
    end else if (wr_ok && wr_port != `GPW_MISC_SLOT) begin
      unique case (aw_addr_q[3:0])
        `GPW_OFS_DATA: data_q[wr_port] <= wr_val;
        `GPW_OFS_DIR: dir_q[wr_port] <= wr_val;
        `GPW_OFS_PULL: pull_q[wr_port] <= wr_val;
        default: ;
      endcase
    end
  end

  // Port A wake enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_en <= `GPW_RST_WAKE;
    end else if (wr_ok && aw_addr_q == `GPW_ADDR_WAKE) begin
      wake_en <= w_data_q;
    end
  end

  // Core power state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= GPW_RUN;
      wake <= 1'b0;
    end else begin
      wake <= wake_hit;
      if (wake_hit) begin
        state <= GPW_RUN;
      end else if (state == GPW_RUN && wr_ok && aw_addr_q == `GPW_ADDR_CTRL &&
                   w_data_q[`GPW_CTRL_HALT_BIT]) begin
        state <= w_data_q[`GPW_CTRL_IDLE_BIT] ? GPW_IDLE : GPW_SLEEP;
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= `GPW_RST_STAT;
      mask <= `GPW_RST_MASK;
    end else begin
      if (wr_ok && aw_addr_q == `GPW_ADDR_MASK) begin
        mask <= w_data_q;
      end
      stat[`GPW_STAT_WAKE_BIT] <=
        (stat[`GPW_STAT_WAKE_BIT] &
         ~(wr_ok && aw_addr_q == `GPW_ADDR_STAT && w_data_q[`GPW_STAT_WAKE_BIT])) |
        wake_hit;
    end
  end

  // Read value: inputs sampled now, outputs from the latch
  always_comb begin
    logic [2:0] rp;
    gpw_byte_t m;
    rp = s_axi_araddr[6:4];
    m = impl_mask(rp);
    next_rdata = 8'h00;
    if (!unmapped(s_axi_araddr)) begin
      if (rp == `GPW_MISC_SLOT) begin
        unique case (s_axi_araddr)
          `GPW_ADDR_WAKE: next_rdata = wake_en;
          `GPW_ADDR_CTRL: next_rdata = {6'h00, state == GPW_IDLE, state != GPW_RUN};
          `GPW_ADDR_STAT: next_rdata = stat;
          `GPW_ADDR_MASK: next_rdata = mask;
          default: next_rdata = 8'h00;
        endcase
      end else begin
        unique case (s_axi_araddr[3:0])
          `GPW_OFS_DATA: next_rdata = m & ((dir_q[rp] & pin_sync[rp*8 +: 8]) |
                                          (~dir_q[rp] & data_q[rp]));
          `GPW_OFS_DIR: next_rdata = m & dir_q[rp];
          `GPW_OFS_PULL: next_rdata = m & pull_q[rp];
          default: next_rdata = 8'h00;
        endcase
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GPW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, next_rdata};
      s_axi_rresp <= unmapped(s_axi_araddr) ? `GPW_RESP_DECERR : `GPW_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pad drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_out <= '0;
      pins_oe <= '0;
      pins_pullup <= '0;
    end else begin
      for (int p = 0; p < 7; p++) begin
        pins_out[p*8 +: 8] <= data_q[p] & impl_mask(3'(p));
        pins_oe[p*8 +: 8] <= ~dir_q[p] & impl_mask(3'(p));
        pins_pullup[p*8 +: 8] <= pull_q[p] & dir_q[p] & impl_mask(3'(p));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_halted <= 1'b0;
      core_idle <= 1'b0;
      irq <= 1'b0;
    end else begin
      core_halted <= (state != GPW_RUN);
      core_idle <= (state == GPW_IDLE);
      irq <= |(stat & mask);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_halt_write;
    wr_ok && aw_addr_q == `GPW_ADDR_CTRL && w_data_q[`GPW_CTRL_HALT_BIT] &&
      state == GPW_RUN && !wake_hit;
  endsequence

  sequence s_falling_pa;
    state != GPW_RUN ##1 (state != GPW_RUN && fall != 8'h00);
  endsequence

  a_pullup_input_only: assert property ((pins_pullup & pins_oe) == 56'h0)
    else $error("pull-high active on an output pin");

  a_pullup_follows_write: assert property (
    (wr_ok && aw_addr_q == 8'h08) |-> ##2
      (pins_pullup[7:0] == ($past(w_data_q, 2) & ~pins_oe[7:0])))
    else $error("port A pull-high does not follow its register");

  a_read_high_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data has bits set above the register width");

  a_port_b_width: assert property ((CONFIG < 2) |->
    (pins_oe[15:14] == 2'b00 && pins_pullup[15:14] == 2'b00))
    else $error("port B drives an unimplemented pin");

  a_port_c_width: assert property ((CONFIG == 0) |-> pins_oe[23:20] == 4'h0)
    else $error("port C drives an unimplemented pin");

  a_port_f_width: assert property ((CONFIG == 2) |-> pins_oe[47:42] == 6'h00)
    else $error("port F drives an unimplemented pin");

  a_port_g_width: assert property (
    pins_oe[55:50] == 6'h00 && (CONFIG == 3 || pins_oe[49:48] == 2'b00))
    else $error("port G drives an unimplemented pin");

  a_halt_entry: assert property (s_halt_write |-> ##2 core_halted)
    else $error("halt command did not halt the core");

  a_wake_release: assert property (s_falling_pa |-> ##1 wake ##1 !core_halted)
    else $error("falling edge on enabled pin did not wake the core");

  a_wake_needs_enable: assert property (
    (state != GPW_RUN && (pa_prev & ~pin_sync[7:0] & ~wake_en) != 8'h00 &&
     (pa_prev & ~pin_sync[7:0] & wake_en) == 8'h00) |=> !wake)
    else $error("wake raised with no pin enabled");

  a_wake_sticky: assert property (wake |-> stat[`GPW_STAT_WAKE_BIT])
    else $error("wake event not recorded in status");

  a_oe_from_dir: assert property (
    (wr_ok && aw_addr_q == 8'h04) |-> ##2
      (pins_oe[7:0] == ~$past(w_data_q, 2)))
    else $error("port A drive does not follow direction");

endmodule

`default_nettype wire

// ==== bench/gpw_switch_model.sv ====
`default_nettype none
module gpw_switch_model (
  input wire logic aclk,
  input wire logic [55:0] pins_out,
  input wire logic [55:0] pins_oe,
  input wire logic [55:0] pins_pullup,
  input wire logic [55:0] sw_closed,
  output logic [55:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [55:0] flt = 56'h0;
  // Undriven pin keeps changing, so a stale level never reads as valid
  always @(posedge aclk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 56; i++) begin
      pins_in[i] = pins_oe[i] ? pins_out[i] :
                   sw_closed[i] ? 1'b0 : pins_pullup[i] ? 1'b1 : flt[i];
    end
  end
endmodule
`default_nettype wire

// ==== bench/gpw_ports_tb.sv ====
`default_nettype none
module gpw_ports_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CFG = 3;
  localparam logic [7:0] IMP [4][7] = '{
    '{8'hff, 8'h3f, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'hff, 8'h3f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00},
    '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_halted, core_idle, wake, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, m, d, dr, pu, s, dm, en;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [55:0] pins_in, pins_out, pins_oe, pins_pullup, sw;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int p, k, j, n;

  gpw_ports #(.CONFIG(CFG)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .pins_out, .pins_oe, .pins_pullup,
    .core_halted, .core_idle, .wake, .irq);
  gpw_switch_model partner (.aclk, .pins_out, .pins_oe, .pins_pullup, .sw_closed(sw), .pins_in);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] x, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    x = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] x;
    logic [1:0] rs;
    rd(a, x, rs);
    chk(nm, e, x);
    chk("rresp", 32'h0, 32'(rs));
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    sw = 56'h0;
    n = $urandom(77465);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int q = 0; q < 7; q++) begin
      rc(8'(16 * q + 4), 32'(IMP[CFG][q]), "dir reset");
      rc(8'(16 * q + 8), 32'h0, "pull reset");
    end
    rc(8'h70, 32'h0, "wake enable reset");
    s_axi_wstrb <= 4'h0;
    wr(8'h70, 8'hff, r);
    chk("bresp no strobe", 32'h0, 32'(r));
    s_axi_wstrb <= 4'hf;
    rc(8'h70, 32'h0, "wake enable no strobe");
    wr(8'h1c, 8'h5a, r);
    chk("bresp unmapped", 32'h3, 32'(r));
    rd(8'h90, v, r);
    chk("rresp unmapped", 32'h3, 32'(r));
    chk("rdata unmapped", 32'h0, v);
    for (int t = 0; t < 14; t++) begin
      p = t % 7;
      m = IMP[CFG][p];
      {d, dr, pu, s} = $urandom;
      sw[8 * p +: 8] <= s;
      wr(8'(16 * p), d, r);
      wr(8'(16 * p + 4), dr, r);
      wr(8'(16 * p + 8), pu, r);
      chk("bresp", 32'h0, 32'(r));
      repeat (2) @(posedge aclk);
      chk("oe", ~dr & m, pins_oe[8 * p +: 8]);
      chk("pullup", pu & dr & m, pins_pullup[8 * p +: 8]);
      chk("out", d & m, pins_out[8 * p +: 8]);
      rc(8'(16 * p + 4), dr & m, "dir");
      rc(8'(16 * p + 8), pu & m, "pull");
      rd(8'(16 * p), v, r);
      dm = ~m | ~dr | s | pu;
      chk("data", (~dr & d | dr & ~s & pu) & m & dm, v & dm);
    end
    sw <= 56'h0;
    wr(8'h04, 8'hff, r);
    wr(8'h08, 8'hff, r);
    for (int i = 0; i < 2; i++) begin
      k = $urandom % 8;
      j = (k + 1) % 8;
      en = (8'($urandom) | (8'h01 << k)) & ~(8'h01 << j);
      wr(8'h7c, 8'(1 - i), r);
      wr(8'h70, en, r);
      rc(8'h70, en, "wake enable");
      wr(8'h74, 8'(2 * i + 1), r);
      @(posedge aclk);
      chk("halted", 32'h1, core_halted);
      chk("idle", 32'(i), core_idle);
      rc(8'h74, 32'(2 * i + 1), "ctrl");
      sw[j] <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("halted disabled pin", 32'h1, core_halted);
      sw[k] <= 1'b1;
      n = 0;
      while (wake !== 1'b1 && n < 10) begin
        @(posedge aclk);
        n++;
      end
      chk("wake pulse", 32'h1, wake);
      repeat (2) @(posedge aclk);
      chk("halted after wake", 32'h0, core_halted);
      rc(8'h78, 32'h1, "status");
      chk("irq", 32'(1 - i), irq);
      wr(8'h78, 8'h01, r);
      @(posedge aclk);
      chk("irq clear", 32'h0, irq);
      rc(8'h78, 32'h0, "status clear");
      sw <= 56'h0;
      repeat (4) @(posedge aclk);
    end
    conclude();
  end
endmodule
`default_nettype wire
